// file: ec_control_device.sv
// canceler mode, control and receive gain register logic of the device end
`include "ec_defs.svh"
`default_nettype none

// Behaviour
// [R1] dual mode: both cancelers, 44/15 ms
// [R2] single mode: acoustic only, 59 ms
// [R3] host never programs reserved mode code
// [R4] mode bits ORed with select pins
// [R5] initial mode re-entered only by powerdown
// [R6] memory write stores data at address
// [R7] memory writes only in initial mode
// [R8] pad bit enables attenuators and amplifiers
// [R9] host resets coefficients after pad change
// [R10] controls sampled on frame sync, held
// [R11] slope bypass halts the slope filter
// [R12] pad, slope, noise-low ORed with pins
// [R13] noise select picks attenuation or bypass
// [R14] noise attenuation latched at initial release
// [R15] noise bypass switchable any time
// [R16] bypass passes data, normal cancels noise
// [R17] receive gain 3 dB steps, mute code
// [R18] register mute code differs from pins
// [R19] host holds gain pins at zero
// [R20] host keeps reserved bits zero
// [R21] initial mode about 200 ms after release
// [R22] initial mode: outputs off, cancelers stopped
// [R23] memory write outside initial mode ignored
module ec_control_device
	import ec_pkg::*;
#(
	parameter int WAKE_CYCLES  = `EC_WAKE_MS * `EC_CLK_KHZ,
	parameter int FRAME_CYCLES = `EC_CLK_KHZ * 1000 / `EC_FRAME_HZ,
	parameter int MEM_AW       = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	ec_ctrl_if.device         link,
	input  wire logic         host_select_pin,
	input  wire logic         canceler_select_pin,
	input  wire logic         pad_bypass_pin,
	input  wire logic         slope_bypass_pin,
	input  wire logic         noise_select_low_pin,
	input  wire logic [MEM_AW-1:0] mem_rd_addr,
	output logic [15:0]       mem_rd_data,
	output logic              acoustic_enable,
	output logic              line_enable,
	output logic [7:0]        acoustic_delay_ms,
	output logic [7:0]        line_delay_ms,
	output logic              digital_out_enable,
	output logic              inputs_idle,
	output logic              pad_enable,
	output logic [7:0]        pad_level,
	output logic              slope_bypass,
	output logic              noise_active,
	output var nc_sel_t       noise_atten,
	output logic              coef_reset,
	output logic              rx_mute,
	output logic signed [6:0] rx_gain_db,
	output logic              gain_pins_used
);
	generate
		if (MEM_AW < 1 || MEM_AW > 16 || FRAME_CYCLES < 2 || WAKE_CYCLES < 1) begin : g_chk
			$error("ec_control_device: parameter out of range");
		end
	endgenerate

	localparam int PIN_HS = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_PAD = 2;
	localparam int PIN_SLOPE = 3;
	localparam int PIN_NLO = 4;

	typedef struct packed {
		dev_state_t         st;
		logic [31:0]        wake_cnt;
		logic [31:0]        frame_cnt;
		logic               frame_tick;
		logic [4:0]         pin_s1;
		logic [4:0]         pin_s2;
		logic [7:0]         basic;
		logic [7:0]         misc;
		logic [7:0]         rxlvl;
		logic [7:0]         addr_hi;
		logic [7:0]         addr_lo;
		logic [7:0]         data_hi;
		logic [7:0]         data_lo;
		logic [7:0]         pad_lvl;
		logic               noise_hi;
		logic [1:0]         run_mode;
		nc_sel_t            atten;
		logic               s_pad;
		logic               s_slope;
		logic               s_nlo;
		logic               s_rst;
		logic               s_mute;
		logic signed [6:0]  s_gain;
		logic [7:0]         rdata;
		logic [15:0]        mem_q;
	} dev_reg_t;

	dev_reg_t q;
	dev_reg_t d;
	logic [15:0] mem [0:(1<<MEM_AW)-1];
	logic        mem_we;
	logic [1:0]  eff_mode;
	logic        pdn;
	logic        init_ok;
	logic        nlo_eff;
	logic [7:0]  gain_dec;
	logic [15:0] mem_wa;

	// msb mute flag, low bits gain in dB
	function automatic logic [7:0] rx_decode(input logic [5:0] c);
		logic signed [7:0] s;
		begin
			s = {{2{c[5]}}, c};
			if (c != `EC_RX_MUTE_CODE && s <= 8'sh0A && s >= -8'sh14) begin
				rx_decode = {1'b0, 7'(s * 8'sh03)}; // R17
			end else begin
				rx_decode = 8'h80; // R17 R18
			end
		end
	endfunction

	always_comb begin
		d = q;
		mem_we = 1'b0;
		d.frame_tick = 1'b0;
		d.pin_s1 = {noise_select_low_pin, slope_bypass_pin, pad_bypass_pin,
			canceler_select_pin, host_select_pin};
		d.pin_s2 = q.pin_s1;
		eff_mode = q.basic[1:0] | {q.pin_s2[PIN_HS], q.pin_s2[PIN_CS]}; // R4
		pdn = link.powerdown_reset | q.basic[`EC_BASIC_PDN];
		init_ok = (q.st != ST_RUN);
		nlo_eff = q.misc[`EC_MISC_NOISE_LO] | q.pin_s2[PIN_NLO]; // R12
		gain_dec = rx_decode(q.rxlvl[5:0]);
		mem_wa = {q.addr_hi, q.addr_lo};
		if (q.frame_cnt >= 32'(FRAME_CYCLES - 1)) begin
			d.frame_cnt = 32'h0;
			d.frame_tick = 1'b1;
		end else begin
			d.frame_cnt = q.frame_cnt + 32'h1;
		end
		if (link.reg_wr) begin
			unique case (link.reg_addr)
				`EC_IDX_BASIC: d.basic = init_ok ? link.reg_wdata :
					{link.reg_wdata[7:6], q.basic[5:0]};
				`EC_IDX_MISC: begin
					d.misc = link.reg_wdata & `EC_MISC_MASK;
					d.misc[`EC_MISC_MEMWR] = link.reg_wdata[`EC_MISC_MEMWR] &
						(q.st == ST_INITIAL); // R23
					if (!init_ok) begin
						d.misc[`EC_MISC_MEMWR] = q.misc[`EC_MISC_MEMWR];
					end
					mem_we = link.reg_wdata[`EC_MISC_MEMWR] && (q.st == ST_INITIAL); // R6 R7 R23
				end
				`EC_IDX_RXLVL: d.rxlvl = link.reg_wdata & `EC_RXLVL_MASK;
				`EC_IDX_ADDR_HI: d.addr_hi = link.reg_wdata;
				`EC_IDX_ADDR_LO: d.addr_lo = link.reg_wdata;
				`EC_IDX_DATA_HI: d.data_hi = link.reg_wdata;
				`EC_IDX_DATA_LO: d.data_lo = link.reg_wdata;
				`EC_IDX_PAD_LEVEL: d.pad_lvl = link.reg_wdata;
				`EC_IDX_NOISE_HI: if (init_ok) begin
					d.noise_hi = link.reg_wdata[`EC_NOISE_HI_BIT];
				end
				default: ;
			endcase
		end
		unique case (link.reg_addr)
			`EC_IDX_BASIC: d.rdata = q.basic;
			`EC_IDX_MISC: d.rdata = q.misc;
			`EC_IDX_RXLVL: d.rdata = q.rxlvl;
			`EC_IDX_ADDR_HI: d.rdata = q.addr_hi;
			`EC_IDX_ADDR_LO: d.rdata = q.addr_lo;
			`EC_IDX_DATA_HI: d.rdata = q.data_hi;
			`EC_IDX_DATA_LO: d.rdata = q.data_lo;
			`EC_IDX_PAD_LEVEL: d.rdata = q.pad_lvl;
			`EC_IDX_NOISE_HI: d.rdata = {5'h00, q.noise_hi, 2'h0};
			default: d.rdata = 8'h00;
		endcase
		// sampled only on the frame tick
		if (q.frame_tick) begin
			d.s_pad = q.misc[`EC_MISC_PAD] | q.pin_s2[PIN_PAD]; // R8 R10 R12
			d.s_slope = q.misc[`EC_MISC_SLOPE] | q.pin_s2[PIN_SLOPE]; // R10 R11 R12
			d.s_nlo = nlo_eff; // R10 R15
			d.s_rst = q.basic[`EC_BASIC_RST]; // R10
			d.s_mute = gain_dec[7]; // R10 R17
			d.s_gain = signed'(gain_dec[6:0]);
		end
		unique case (q.st)
			ST_POWERDOWN: if (!pdn) begin
				d.st = ST_WAKE;
				d.wake_cnt = 32'h0;
			end
			ST_WAKE: begin
				d.wake_cnt = q.wake_cnt + 32'h1;
				if (q.wake_cnt >= 32'(WAKE_CYCLES - 1)) begin
					d.st = (eff_mode == 2'b00) ? ST_INITIAL : ST_RUN; // R21
					d.run_mode = eff_mode;
					d.atten = nc_sel_t'({q.noise_hi, nlo_eff}); // R14
				end
			end
			ST_INITIAL: if (eff_mode != 2'b00) begin
				d.st = ST_RUN;
				d.run_mode = eff_mode;
				d.atten = nc_sel_t'({q.noise_hi, nlo_eff}); // R14
			end
			ST_RUN: d.st = ST_RUN; // R5
		endcase
		if (pdn) begin
			d = '0;
			d.st = ST_POWERDOWN; // R5
			d.pin_s1 = q.pin_s1;
			d.pin_s2 = q.pin_s2;
			d.frame_cnt = d.frame_cnt;
			d.pad_lvl = `EC_PAD_LVL_RESET;
			d.basic[`EC_BASIC_PDN] = link.reg_wr && link.reg_addr == `EC_IDX_BASIC ?
				link.reg_wdata[`EC_BASIC_PDN] : q.basic[`EC_BASIC_PDN];
		end
		d.mem_q = mem[mem_rd_addr];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
			q.pad_lvl <= `EC_PAD_LVL_RESET;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			mem[mem_wa[MEM_AW-1:0]] <= {q.data_hi, q.data_lo}; // R6
		end
	end

	always_comb begin
		acoustic_enable = (q.st == ST_RUN) && q.run_mode[1]; // R1 R2 R22
		line_enable = (q.st == ST_RUN) && (q.run_mode == 2'b10); // R1 R2
		acoustic_delay_ms = (q.run_mode == 2'b10) ? `EC_DUAL_AC_MS :
			(q.run_mode == 2'b11) ? `EC_SINGLE_AC_MS : 8'h00; // R1 R2
		line_delay_ms = (q.run_mode == 2'b10) ? `EC_DUAL_LN_MS : 8'h00; // R1
		digital_out_enable = (q.st == ST_RUN); // R22
		inputs_idle = (q.st != ST_RUN); // R22
		pad_enable = q.s_pad; // R8
		pad_level = q.pad_lvl;
		slope_bypass = q.s_slope; // R11
		noise_active = (q.st == ST_RUN) && ({q.noise_hi, q.s_nlo} != NC_BYPASS); // R13 R16
		noise_atten = q.atten; // R13 R14
		coef_reset = q.s_rst;
		rx_mute = q.s_mute; // R17
		rx_gain_db = q.s_gain;
		gain_pins_used = |link.transmit_gain_pins;
		mem_rd_data = q.mem_q;
		link.reg_rdata = q.rdata;
		link.frame_sync = q.frame_tick; // R10
		link.dev_state = q.st;
	end
endmodule
`default_nettype wire

// file: ec_control_host.sv
// host end: takes software orders over AHB-Lite and programs the device
`include "ec_defs.svh"
`default_nettype none
module ec_control_host
	import ec_pkg::*;
#(
	parameter int HOLD_CYCLES = (`EC_HOLD_US * `EC_CLK_KHZ + 999) / 1000
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	ec_ctrl_if.host           link,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic [31:0]       hrdata,
	output logic              hreadyout,
	output logic              hresp
);
	generate
		if (HOLD_CYCLES < 1) begin : g_chk
			$error("ec_control_host: HOLD_CYCLES must be positive");
		end
	endgenerate

	typedef struct packed {
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_addr;
		logic [31:0] hrdata;
		seq_state_t  seq;
		logic [31:0] hold_cnt;
		logic [3:0]  wr_addr;
		logic [7:0]  wr_data;
		logic [1:0]  coef_step;
		logic [7:0]  basic_sh;
		logic        pad_sh;
		logic        refused;
		logic        pdn;
		logic [3:0]  rdsel;
		logic [7:0]  rb;
	} host_reg_t;

	host_reg_t q;
	host_reg_t d;
	logic      stall;
	logic [3:0] c_idx;
	logic [7:0] c_dat;

	always_comb begin
		d = q;
		stall = q.ap_valid && q.ap_write && q.ap_addr == `EC_H_CMD && q.seq != SEQ_IDLE;
		c_idx = hwdata[11:8];
		c_dat = hwdata[7:0];
		if (q.ap_valid && q.ap_write && !stall) begin
			unique case (q.ap_addr)
				`EC_H_CMD: begin
					if (c_idx == `EC_IDX_BASIC && c_dat[1:0] == `EC_MODE_RESERVED) begin
						d.refused = 1'b1; // R3
					end else begin
						d.refused = 1'b0;
						d.seq = SEQ_WRITE;
						d.wr_addr = c_idx;
						d.wr_data = c_dat;
						if (c_idx == `EC_IDX_MISC) begin
							d.wr_data = c_dat & `EC_MISC_MASK; // R20
							if (c_dat[`EC_MISC_PAD] != q.pad_sh) begin
								d.coef_step = 2'h1; // R9
							end
							d.pad_sh = c_dat[`EC_MISC_PAD];
						end
						if (c_idx == `EC_IDX_RXLVL) begin
							d.wr_data = c_dat & `EC_RXLVL_MASK; // R20
						end
						if (c_idx == `EC_IDX_BASIC) begin
							d.basic_sh = c_dat;
						end
					end
				end
				`EC_H_CONTROL: d.pdn = hwdata[0]; // R5 R14
				`EC_H_RDSEL: d.rdsel = hwdata[3:0];
				default: ;
			endcase
		end
		if (!stall) begin
			d.ap_valid = hready && hsel && htrans[1];
			d.ap_write = hwrite;
			d.ap_addr = haddr[7:0];
			unique case (haddr[7:0])
				`EC_H_STATUS: d.hrdata = {16'h0, q.rb, 4'h0, 2'b00, q.refused, 1'b0}; // R3
				`EC_H_CONTROL: d.hrdata = {31'h0, q.pdn};
				`EC_H_RDSEL: d.hrdata = {28'h0, q.rdsel};
				default: d.hrdata = 32'h0;
			endcase
		end
		unique case (q.seq)
			SEQ_IDLE: d.rb = link.reg_rdata;
			SEQ_WRITE: begin
				d.seq = SEQ_HOLD;
				d.hold_cnt = 32'h0;
			end
			SEQ_HOLD: begin
				d.hold_cnt = q.hold_cnt + 32'h1;
				if (q.hold_cnt >= 32'(HOLD_CYCLES - 1)) begin // R10
					d.seq = SEQ_IDLE;
					if (q.coef_step != 2'h0) begin
						d.seq = SEQ_WRITE; // R9
						d.wr_addr = `EC_IDX_BASIC;
						d.wr_data = q.basic_sh;
						d.wr_data[`EC_BASIC_RST] = (q.coef_step == 2'h1);
						d.coef_step = (q.coef_step == 2'h1) ? 2'h2 : 2'h0;
					end
				end
			end
			default: d.seq = SEQ_IDLE;
		endcase
		if (q.pdn) begin
			d.basic_sh = `EC_REG_RESET;
			d.pad_sh = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	always_comb begin
		hrdata = q.hrdata;
		hreadyout = !stall;
		hresp = 1'b0;
		link.reg_wr = (q.seq == SEQ_WRITE);
		link.reg_addr = (q.seq == SEQ_IDLE) ? q.rdsel : q.wr_addr;
		link.reg_wdata = q.wr_data;
		link.powerdown_reset = q.pdn;
		link.transmit_gain_pins = 4'h0; // R19
	end
endmodule
`default_nettype wire

// file: ec_ctrl_if.sv
// link between the host controller and the canceler control device
`default_nettype none
interface ec_ctrl_if;
	logic                   reg_wr;
	logic [3:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic [7:0]             reg_rdata;
	logic                   powerdown_reset;
	logic [3:0]             transmit_gain_pins;
	logic                   frame_sync;
	ec_pkg::dev_state_t     dev_state;

	modport device (
		input  reg_wr, reg_addr, reg_wdata, powerdown_reset, transmit_gain_pins,
		output reg_rdata, frame_sync, dev_state
	);
	modport host (
		output reg_wr, reg_addr, reg_wdata, powerdown_reset, transmit_gain_pins,
		input  reg_rdata, frame_sync, dev_state
	);
endinterface
`default_nettype wire

// file: ec_defs.svh
// offsets, field positions, reset values and timing counts of the canceler control
`ifndef EC_DEFS_SVH
`define EC_DEFS_SVH

// device register indices
`define EC_IDX_BASIC      4'h0
`define EC_IDX_MISC       4'h1
`define EC_IDX_RXLVL      4'h2
`define EC_IDX_ADDR_HI    4'h6
`define EC_IDX_ADDR_LO    4'h7
`define EC_IDX_DATA_HI    4'h8
`define EC_IDX_DATA_LO    4'h9
`define EC_IDX_PAD_LEVEL  4'hA
`define EC_IDX_NOISE_HI   4'hC

// field positions
`define EC_BASIC_PDN      7
`define EC_BASIC_RST      6
`define EC_MISC_MEMWR     7
`define EC_MISC_PAD       2
`define EC_MISC_SLOPE     1
`define EC_MISC_NOISE_LO  0
`define EC_NOISE_HI_BIT   2

// masks and values
`define EC_REG_RESET      8'h00
`define EC_BASIC_INIT_MSK 8'h3F
`define EC_MISC_MASK      8'h87
`define EC_RXLVL_MASK     8'h3F
`define EC_PAD_LVL_RESET  8'hAA
`define EC_RX_MUTE_CODE   6'h2B
`define EC_MODE_RESERVED  2'h1
`define EC_DUAL_AC_MS     8'h2C
`define EC_DUAL_LN_MS     8'h0F
`define EC_SINGLE_AC_MS   8'h3B

// timing
`define EC_CLK_KHZ        200000
`define EC_WAKE_MS        200
`define EC_FRAME_HZ       8000
`define EC_HOLD_US        250

// host register byte addresses
`define EC_H_CMD          8'h00
`define EC_H_STATUS       8'h04
`define EC_H_CONTROL      8'h08
`define EC_H_RDSEL        8'h0C

`endif

// file: ec_link_assertions.sv
// concurrent checks on the host to device link
`include "ec_defs.svh"
`default_nettype none
module ec_link_assertions
	import ec_pkg::*;
#(
	parameter int FRAME_CYCLES = 8,
	parameter int WAKE_CYCLES  = 20,
	parameter int HOLD_CYCLES  = 10
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       powerdown_reset,
	input wire logic [3:0] transmit_gain_pins,
	input wire logic       frame_sync,
	input wire dev_state_t dev_state
);
	localparam int WAKE_LO = WAKE_CYCLES - 2;
	localparam int WAKE_HI = WAKE_CYCLES + 3;
	localparam int MODE_HI = FRAME_CYCLES + 3;
	localparam int PAD_HI  = HOLD_CYCLES + 4;
	logic pad_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// last pad bit sent
	always_ff @(posedge ref_clk) begin
		if (rst)
			pad_q <= 1'b0;
		else if (reg_wr && reg_addr == `EC_IDX_MISC)
			pad_q <= reg_wdata[`EC_MISC_PAD];
	end
	property p_gain_pins;
		transmit_gain_pins == 4'h0;
	endproperty
	a_gain_pins: assert property (p_gain_pins) else $error("gain pins not zero");
	property p_hold;
		reg_wr |=> !reg_wr [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("link writes too close");
	property p_frame;
		@(posedge ref_clk) disable iff (rst || powerdown_reset)
		frame_sync |=> !frame_sync ##(FRAME_CYCLES - 1) frame_sync;
	endproperty
	a_frame: assert property (p_frame) else $error("frame tick spacing wrong");
	property p_mode_ok;
		reg_wr && reg_addr == `EC_IDX_BASIC |-> reg_wdata[1:0] != `EC_MODE_RESERVED;
	endproperty
	a_mode_ok: assert property (p_mode_ok) else $error("reserved mode sent");
	property p_pdn;
		powerdown_reset |-> ##[1:2] dev_state == ST_POWERDOWN;
	endproperty
	a_pdn: assert property (p_pdn) else $error("powerdown not entered");
	property p_wake;
		@(posedge ref_clk) disable iff (rst || powerdown_reset)
		dev_state == ST_WAKE && $past(dev_state) == ST_POWERDOWN
			|-> ##[WAKE_LO:WAKE_HI] dev_state inside {ST_INITIAL, ST_RUN};
	endproperty
	a_wake: assert property (p_wake) else $error("wake time wrong");
	property p_no_init;
		dev_state == ST_RUN |=> dev_state != ST_INITIAL;
	endproperty
	a_no_init: assert property (p_no_init) else $error("initial re-entered");
	property p_run;
		reg_wr && reg_addr == `EC_IDX_BASIC && reg_wdata[1] && dev_state == ST_INITIAL
			|-> ##[1:MODE_HI] dev_state == ST_RUN;
	endproperty
	a_run: assert property (p_run) else $error("mode not left");
	property p_coef;
		reg_wr && reg_addr == `EC_IDX_MISC && reg_wdata[`EC_MISC_PAD] != pad_q
			|-> ##[1:PAD_HI] reg_wr && reg_addr == `EC_IDX_BASIC && reg_wdata[`EC_BASIC_RST];
	endproperty
	a_coef: assert property (p_coef) else $error("no coefficient reset");
	c_memwr: cover property (reg_wr && reg_addr == `EC_IDX_MISC && reg_wdata[7]);
	c_run: cover property (dev_state == ST_RUN);
	c_pdn: cover property (powerdown_reset ##1 !powerdown_reset);
endmodule
`default_nettype wire

// file: ec_pkg.sv
// types shared by both ends of the canceler control
`default_nettype none
package ec_pkg;
	typedef enum logic [1:0] {
		ST_POWERDOWN = 2'b00,
		ST_WAKE      = 2'b01,
		ST_INITIAL   = 2'b11,
		ST_RUN       = 2'b10
	} dev_state_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_WRITE = 2'b01,
		SEQ_HOLD  = 2'b11
	} seq_state_t;

	typedef enum logic [1:0] {
		NC_ATT_17  = 2'b00,
		NC_BYPASS  = 2'b01,
		NC_ATT_8   = 2'b10,
		NC_ATT_13H = 2'b11
	} nc_sel_t;
endpackage
`default_nettype wire

// file: ec_pkg_fix_note_placeholder.sv
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// file: echo_canceler_mode_gain_control_bench.sv
// bench for the host and device ends of the canceler control
`include "ec_defs.svh"
`default_nettype none
module echo_canceler_mode_gain_control_bench
	import ec_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WAKE  = 20;
	localparam int FRAME = 8;
	localparam int HOLD  = 10;
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic               hsel = 1'b0;
	logic               hwrite = 1'b0;
	logic [31:0]        haddr = 32'h0;
	logic [31:0]        hwdata = 32'h0;
	logic [1:0]         htrans = 2'h0;
	logic [2:0]         hsize = 3'h0;
	logic               hs_pin = 1'b0;
	logic               cs_pin = 1'b0;
	logic               slp_pin = 1'b0;
	logic               pad_pin = 1'b0;
	logic               nlo_pin = 1'b0;
	logic [7:0]         mra = 8'h0;
	logic [31:0]        hrdata, r;
	logic               hreadyout, ac_en, ln_en, dout_en, in_idle, pad_en, slp, nc_act;
	logic               mute, gp_used, crst, hresp;
	logic [15:0]        mem;
	logic [7:0]         ac_d, ln_d, pad_lvl;
	nc_sel_t            nc_att;
	logic signed [6:0]  gain;
	int                 miscompares = 0;
	int                 checks_done = 0;
	ec_ctrl_if link();
	ec_control_device #(.WAKE_CYCLES(WAKE), .FRAME_CYCLES(FRAME)) ec_control_device_i (
		.ref_clk(ref_clk), .rst(rst), .link(link), .host_select_pin(hs_pin),
		.canceler_select_pin(cs_pin), .pad_bypass_pin(pad_pin), .slope_bypass_pin(slp_pin),
		.noise_select_low_pin(nlo_pin), .mem_rd_addr(mra), .mem_rd_data(mem),
		.acoustic_enable(ac_en), .line_enable(ln_en), .acoustic_delay_ms(ac_d),
		.line_delay_ms(ln_d), .digital_out_enable(dout_en), .inputs_idle(in_idle),
		.pad_enable(pad_en), .pad_level(pad_lvl), .slope_bypass(slp), .noise_active(nc_act),
		.noise_atten(nc_att), .coef_reset(crst), .rx_mute(mute), .rx_gain_db(gain),
		.gain_pins_used(gp_used));
	ec_control_host #(.HOLD_CYCLES(HOLD)) ec_control_host_i (
		.ref_clk(ref_clk), .rst(rst), .link(link), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	ec_link_assertions #(.FRAME_CYCLES(FRAME), .WAKE_CYCLES(WAKE), .HOLD_CYCLES(HOLD))
	ec_link_assertions_i (
		.ref_clk(ref_clk), .rst(rst), .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .powerdown_reset(link.powerdown_reset),
		.transmit_gain_pins(link.transmit_gain_pins), .frame_sync(link.frame_sync),
		.dev_state(link.dev_state));
	always #2.5 ref_clk = ~ref_clk;
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 500);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask
	task automatic cmd(input logic [3:0] i, input logic [7:0] d);
		ahb(1'b1, `EC_H_CMD, {20'h0, i, d});
	endtask
	task automatic settle;
		repeat (4 * HOLD + 3 * FRAME) @(posedge ref_clk);
	endtask
	task automatic wait_st(input dev_state_t st);
		int n;
		for (n = 0; n < 300 && link.dev_state !== st; n++) @(posedge ref_clk);
		chk("dev_state", link.dev_state, st);
		if (link.dev_state !== st)
			summarize();
	endtask
	task automatic t_init;
		wait_st(ST_INITIAL);
		chk("pad_level", pad_lvl, 8'hAA);
		chk("dout_en", dout_en, 1'b0);
		chk("in_idle", in_idle, 1'b1);
		chk("ac_en", ac_en, 1'b0);
		chk("gp_used", gp_used, 1'b0);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", r, 16'h0);
		chk("hresp", hresp, 1'b0);
		$display("init done");
	endtask
	task automatic t_mem;
		cmd(4'h6, 8'h00);
		cmd(4'h7, 8'h05);
		cmd(4'h8, 8'hBE);
		cmd(4'h9, 8'hEF);
		cmd(4'hA, 8'h55);
		cmd(4'h1, 8'h80);
		settle();
		mra <= 8'h05;
		repeat (3) @(posedge ref_clk);
		chk("mem", mem, 16'hBEEF);
		chk("pad_lvl_wr", pad_lvl, 8'h55);
		$display("mem done");
	endtask
	task automatic t_ctrl;
		cmd(4'hC, 8'h04);
		cmd(4'h1, 8'h04);
		for (int n = 0; n < 60 && crst !== 1'b1; n++) @(posedge ref_clk);
		chk("coef_rst", crst, 1'b1);
		settle();
		chk("coef_rst_end", crst, 1'b0);
		chk("pad_en", pad_en, 1'b1);
		chk("slp", slp, 1'b0);
		slp_pin <= 1'b1;
		repeat (3 * FRAME) @(posedge ref_clk);
		chk("slp_pin", slp, 1'b1);
		slp_pin <= 1'b0;
		cmd(4'h1, 8'h02);
		settle();
		chk("pad_off", pad_en, 1'b0);
		pad_pin <= 1'b1;
		repeat (3 * FRAME) @(posedge ref_clk);
		chk("pad_pin", pad_en, 1'b1);
		pad_pin <= 1'b0;
		chk("slp_reg", slp, 1'b1);
		cmd(4'h1, 8'h00);
		$display("ctrl done");
	endtask
	task automatic t_run;
		cmd(4'h0, 8'h02);
		wait_st(ST_RUN);
		settle();
		chk("ac_en", ac_en, 1'b1);
		chk("ln_en", ln_en, 1'b1);
		chk("ac_d", ac_d, 8'd44);
		chk("ln_d", ln_d, 8'd15);
		chk("dout_en", dout_en, 1'b1);
		chk("nc_att", nc_att, NC_ATT_8);
		chk("nc_act", nc_act, 1'b1);
		cmd(4'hC, 8'h00);
		cmd(4'h1, 8'h01);
		settle();
		chk("nc_keep", nc_att, NC_ATT_8);
		chk("nc_hi_lo", nc_act, 1'b1);
		cmd(4'h1, 8'h00);
		cmd(4'h8, 8'h12);
		cmd(4'h1, 8'h80);
		settle();
		chk("nc_back", nc_act, 1'b1);
		chk("mem_run", mem, 16'hBEEF);
		cmd(4'h1, 8'h00);
		cmd(4'h0, 8'h01);
		ahb(1'b0, `EC_H_STATUS, 32'h0);
		chk("refused", r[1], 1'b1);
		$display("run done");
	endtask
	task automatic t_gain;
		logic [5:0] gc [5] = '{6'h0A, 6'h00, 6'h3F, 6'h2C, 6'h2B};
		int ge [5] = '{30, 0, -3, -60, 0};
		for (int i = 0; i < 5; i++) begin
			cmd(4'h2, {2'h0, gc[i]});
			settle();
			chk("mute", mute, i == 4);
			if (i < 4)
				chk("gain", gain, 16'(ge[i]));
		end
		ahb(1'b1, `EC_H_RDSEL, 32'h2);
		settle();
		ahb(1'b0, `EC_H_STATUS, 32'h0);
		chk("readback", r[15:8], 8'h2B);
		$display("gain done");
	endtask
	task automatic t_pdn;
		ahb(1'b1, `EC_H_CONTROL, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk("pdn", link.dev_state, ST_POWERDOWN);
		hs_pin <= 1'b1;
		cs_pin <= 1'b1;
		ahb(1'b1, `EC_H_CONTROL, 32'h0);
		wait_st(ST_RUN);
		chk("ac_en", ac_en, 1'b1);
		chk("ln_en", ln_en, 1'b0);
		chk("ac_d", ac_d, 8'd59);
		chk("nc_att17", nc_att, NC_ATT_17);
		cmd(4'h1, 8'h01);
		settle();
		chk("nc_byp", nc_act, 1'b0);
		cmd(4'h1, 8'h00);
		nlo_pin <= 1'b1;
		settle();
		chk("nlo_pin", nc_act, 1'b0);
		nlo_pin <= 1'b0;
		settle();
		chk("nc_norm", nc_act, 1'b1);
		hs_pin <= 1'b0;
		cs_pin <= 1'b0;
		ahb(1'b1, `EC_H_CONTROL, 32'h1);
		repeat (4) @(posedge ref_clk);
		ahb(1'b1, `EC_H_CONTROL, 32'h0);
		wait_st(ST_INITIAL);
		$display("pdn done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_init();
		t_mem();
		t_ctrl();
		t_run();
		t_gain();
		t_pdn();
		summarize();
	end
endmodule
`default_nettype wire
